// >>> shared/flc_pkg.sv
// constants and carrier types of the fault lamp code flasher and trip counters
// assumes one 40 MHz clock and event pulses one cycle wide from the diagnostics
// Overview of operation
// - results mode flashes confirmed and pending codes together, same numbering
// - four decimal digits per code, each as that many blinks, zero as ten
// - thousands digit blinks are 0.6 s on, 0.6 s off
// - lower digit blinks are 0.3 s on, 0.3 s off
// - lamp stays off 1.0 s between digits of one code
// - lamp stays off 1.8 s between two codes
// - with nothing stored the code 0000 is flashed
// - oxygen monitor: lean lights lamp, rich darkens it, open loop holds it
// - first detection stores pending code and pending snapshot
// - detection in two consecutive trips stores confirmed code, snapshot, lamp on
// - lamp-off counter clears on any fault, counts clean drives, lamp off at 3
// - ordinary confirmed code hidden after 40 clean drives, counter clears on recurrence
// - misfire/injection counter counts similar drives, code hidden at 80
// - similar drive: speed within 375 rpm, load within 10 pct, same side of 70 C
// - misfire/injection pending cleared after one similar drive once confirmed
// - ordinary pending cleared after one clean qualifying drive
// - misfire/injection pending and its snapshot cleared at a passing result
// - pending snapshot cleared when the fault recurs in the second trip
// - hidden confirmed code and snapshot stay stored
// - pending code not shown once the second trip passes
// - ignition off returns the lamp to normal warning mode
package flc_pkg;

    // =========================================================
    // timing
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned TICK_HZ     = 1000;
    localparam int unsigned TICK_CYC    = CLK_HZ / TICK_HZ;
    localparam int unsigned T_LONG_MS   = 600;
    localparam int unsigned T_SHORT_MS  = 300;
    localparam int unsigned T_DGAP_MS   = 1000;
    localparam int unsigned T_CGAP_MS   = 1800;
    localparam logic [10:0] T_LONG_TK   = 11'(T_LONG_MS * TICK_HZ / 1000);
    localparam logic [10:0] T_SHORT_TK  = 11'(T_SHORT_MS * TICK_HZ / 1000);
    localparam logic [10:0] T_DGAP_TK   = 11'(T_DGAP_MS * TICK_HZ / 1000);
    localparam logic [10:0] T_CGAP_TK   = 11'(T_CGAP_MS * TICK_HZ / 1000);

    // =========================================================
    // counts and limits
    localparam int unsigned N_SLOTS     = 4;
    localparam logic [5:0]  CNT_A_LIM   = 6'd40;
    localparam logic [6:0]  CNT_C_LIM   = 7'd80;
    localparam logic [1:0]  CNT_B_LIM   = 2'd3;
    localparam logic [13:0] SPEED_TOL   = 14'd375;
    localparam logic [11:0] LOAD_TOL_INV = 12'd10;
    localparam logic signed [7:0] TEMP_SPLIT = 8'sd70;
    localparam logic [3:0]  BLINKS_ZERO = 4'hA;
    localparam logic [15:0] CODE_NONE   = 16'h0000;

    // =========================================================
    // types
    typedef struct packed {
        logic [13:0]       rpm;
        logic [7:0]        load;
        logic signed [7:0] temp;
    } flc_snap_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  slot;
        logic [15:0] code;
        logic        misfire;
    } flc_fault_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] slot;
    } flc_pass_t;

    typedef struct packed {
        logic valid;
        logic qual_a;
        logic qual_b;
    } flc_trip_t;

    typedef struct packed {
        logic        pend;
        logic        hide;
        logic        conf;
        logic        show;
        logic        psnap_v;
        logic        det;
        logic        misfire;
        logic [15:0] code;
        flc_snap_t   psnap;
        flc_snap_t   csnap;
        logic [5:0]  cnt_a;
        logic [6:0]  cnt_c;
    } flc_slot_t;

    typedef enum logic [4:0] {
        FL_IDLE = 5'b00001,
        FL_ON   = 5'b00010,
        FL_OFF  = 5'b00100,
        FL_DGAP = 5'b01000,
        FL_CGAP = 5'b10000
    } flc_fl_t;

endpackage

// >>> logic/flc_top.sv
// fault lamp code flasher, oxygen monitor mirror and trip-based code counters
// assumes event inputs are one-cycle pulses synchronous to clk, slot chosen upstream
`timescale 1ns/100ps
module flc_top #(
    parameter int unsigned TICK_CYCLES = flc_pkg::TICK_CYC
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               ign_on,
    input  wire logic               eng_running,
    input  wire logic               diag_enter,
    input  wire logic               erase_req,
    input  wire logic               closed_loop,
    input  wire logic               o2_lean,
    input  wire flc_pkg::flc_snap_t op_now,
    input  wire flc_pkg::flc_fault_t fault_in,
    input  wire flc_pkg::flc_pass_t pass_in,
    input  wire flc_pkg::flc_trip_t trip_in,
    output logic                    fault_lamp,
    output logic                    warn_lamp,
    output logic                    diag_active
);
    import flc_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        flc_slot_t [N_SLOTS-1:0] slots;
        logic [1:0]              cnt_b;
        logic                    warn;
        logic                    diag;
        logic                    lamp;
        logic [1:0]              scan_idx;
        logic                    scan_hit;
        logic [1:0][15:0]        fifo;
        logic                    wp;
        logic                    rp;
        logic [1:0]              fcnt;
        flc_fl_t                 fl;
        logic [15:0]             code;
        logic [1:0]              digit;
        logic [3:0]              blinks;
        logic [10:0]             timer;
        logic [15:0]             pre;
    } flc_state_t;

    flc_state_t s_q;
    flc_state_t s_d;

    function automatic logic flc_similar(flc_snap_t fz, flc_snap_t now);
        logic [13:0] dspd;
        logic [7:0]  dld;
        dspd = (now.rpm >= fz.rpm) ? now.rpm - fz.rpm : fz.rpm - now.rpm;
        dld  = (now.load >= fz.load) ? now.load - fz.load : fz.load - now.load;
        return (dspd <= SPEED_TOL) &&
               ((12'(dld) * LOAD_TOL_INV) <= 12'(12'(fz.load) * 12'd1)) &&
               ((now.temp < TEMP_SPLIT) == (fz.temp < TEMP_SPLIT));
    endfunction

    function automatic logic [3:0] flc_blinks(logic [3:0] nib);
        return (nib == 4'h0) ? BLINKS_ZERO : nib;
    endfunction

    function automatic logic flc_visible(flc_slot_t sl);
        return (sl.conf && sl.show) || (sl.pend && !sl.hide);
    endfunction

    logic        results_mode;
    logic        o2_mode;
    logic        fifo_ready;
    logic        fifo_valid;
    logic        push;
    logic        pop;
    logic [15:0] push_code;
    logic        tick;
    logic        fl_adv;
    logic        any_det;

    always_comb begin
        results_mode = s_q.diag && !eng_running;
        o2_mode      = s_q.diag && eng_running;
        fifo_ready   = (s_q.fcnt != 2'd2);
        fifo_valid   = (s_q.fcnt != 2'd0);
        tick         = (s_q.pre == 16'(TICK_CYCLES - 1));
        fl_adv       = tick && (s_q.timer == 11'h000);
        any_det      = 1'b0;
        push         = 1'b0;
        push_code    = CODE_NONE;
        pop          = 1'b0;
        s_d          = s_q;

        // =====================================================
        // mode
        if (diag_enter) begin
            s_d.diag = 1'b1;
        end
        if (!ign_on) begin
            s_d.diag = 1'b0;
        end

        // =====================================================
        // fault memory and trip counters
        for (int i = 0; i < N_SLOTS; i++) begin
            any_det = any_det | s_q.slots[i].det;
            if (trip_in.valid && !s_q.slots[i].det) begin
                if (!s_q.slots[i].misfire) begin
                    if (trip_in.qual_a && s_q.slots[i].conf && s_q.slots[i].show) begin
                        s_d.slots[i].cnt_a = s_q.slots[i].cnt_a + 6'd1;
                        if (s_q.slots[i].cnt_a + 6'd1 == CNT_A_LIM) begin
                            s_d.slots[i].show = 1'b0;
                        end
                    end
                    if (trip_in.qual_b && s_q.slots[i].pend) begin
                        s_d.slots[i].pend    = 1'b0;
                        s_d.slots[i].psnap_v = 1'b0;
                    end
                end else if (s_q.slots[i].conf && flc_similar(s_q.slots[i].csnap, op_now)) begin
                    s_d.slots[i].cnt_c = s_q.slots[i].cnt_c + 7'd1;
                    s_d.slots[i].pend  = 1'b0;
                    if (s_q.slots[i].cnt_c + 7'd1 == CNT_C_LIM) begin
                        s_d.slots[i].show = 1'b0;
                    end
                end
            end
            if (trip_in.valid) begin
                s_d.slots[i].det  = 1'b0;
                s_d.slots[i].hide = 1'b0;
            end
            if (pass_in.valid && pass_in.slot == 2'(i)) begin
                if (s_q.slots[i].misfire) begin
                    s_d.slots[i].pend    = 1'b0;
                    s_d.slots[i].psnap_v = 1'b0;
                end else if (s_q.slots[i].pend) begin
                    s_d.slots[i].hide = 1'b1;
                end
            end
            // detection follows the trip and pass clears so a fault beats them in the same cycle; a later erase still wins
            if (fault_in.valid && fault_in.slot == 2'(i)) begin
                s_d.slots[i].det     = 1'b1;
                s_d.slots[i].misfire = fault_in.misfire;
                s_d.slots[i].code    = fault_in.code;
                s_d.slots[i].hide    = 1'b0;
                s_d.slots[i].cnt_a   = 6'd0;
                s_d.slots[i].cnt_c   = 7'd0;
                if (s_q.slots[i].pend && !s_q.slots[i].det) begin
                    s_d.slots[i].conf    = 1'b1;
                    s_d.slots[i].show    = 1'b1;
                    s_d.slots[i].csnap   = op_now;
                    s_d.slots[i].psnap_v = 1'b0;
                    s_d.warn             = 1'b1;
                end else if (!s_q.slots[i].pend) begin
                    s_d.slots[i].pend    = 1'b1;
                    s_d.slots[i].psnap   = op_now;
                    s_d.slots[i].psnap_v = 1'b1;
                end
            end
        end

        // lamp-off counter
        if (trip_in.valid && trip_in.qual_b && !any_det && !fault_in.valid && s_q.warn) begin
            s_d.cnt_b = s_q.cnt_b + 2'd1;
            if (s_q.cnt_b + 2'd1 == CNT_B_LIM) begin
                s_d.warn  = 1'b0;
                s_d.cnt_b = 2'd0;
            end
        end
        if (fault_in.valid) begin
            s_d.cnt_b = 2'd0;
        end

        // erase only honoured in results mode; the pedal timing lives upstream
        if (erase_req && results_mode) begin
            s_d.slots = '0;
            s_d.cnt_b = 2'd0;
            s_d.warn  = 1'b0;
        end

        // =====================================================
        // scanner: walks the slots, feeds codes into the two-entry buffer
        if (results_mode && fifo_ready) begin
            if (flc_visible(s_q.slots[s_q.scan_idx])) begin
                push      = 1'b1;
                push_code = s_q.slots[s_q.scan_idx].code;
            end else if (s_q.scan_idx == 2'(N_SLOTS - 1) && !s_q.scan_hit) begin
                push      = 1'b1;
                push_code = CODE_NONE;
            end
            s_d.scan_idx = s_q.scan_idx + 2'd1;
            s_d.scan_hit = (s_q.scan_idx == 2'(N_SLOTS - 1)) ? 1'b0 :
                           (s_q.scan_hit | flc_visible(s_q.slots[s_q.scan_idx]));
        end

        // =====================================================
        // flasher: prescaler restarts on each phase so phases are exact
        s_d.pre = tick ? 16'h0000 : s_q.pre + 16'h0001;
        if (tick && s_q.timer != 11'h000) begin
            s_d.timer = s_q.timer - 11'h001;
        end
        unique case (s_q.fl)
            FL_IDLE: begin
                s_d.pre = 16'h0000;
            end
            FL_ON: begin
                if (fl_adv) begin
                    s_d.fl    = FL_OFF;
                    s_d.timer = ((s_q.digit == 2'd0) ? T_LONG_TK : T_SHORT_TK) - 11'h001;
                    if (s_q.blinks == 4'h1) begin
                        // last blink of a digit: its off time is the gap itself
                        s_d.fl    = (s_q.digit == 2'd3) ? FL_CGAP : FL_DGAP;
                        s_d.timer = ((s_q.digit == 2'd3) ? T_CGAP_TK : T_DGAP_TK) - 11'h001;
                    end
                end
            end
            FL_OFF: begin
                if (fl_adv) begin
                    s_d.fl     = FL_ON;
                    s_d.blinks = s_q.blinks - 4'h1;
                    s_d.timer  = ((s_q.digit == 2'd0) ? T_LONG_TK : T_SHORT_TK) - 11'h001;
                end
            end
            FL_DGAP: begin
                if (fl_adv) begin
                    s_d.fl     = FL_ON;
                    s_d.digit  = s_q.digit + 2'd1;
                    s_d.blinks = flc_blinks(s_q.code[4'(11 - 4 * s_q.digit) -: 4]);
                    s_d.timer  = T_SHORT_TK - 11'h001;
                end
            end
            FL_CGAP: begin
                if (fl_adv) begin
                    s_d.fl = FL_IDLE;
                end
            end
        endcase
        // a code gap ends straight in the next code, else the gap grows a cycle
        if (fifo_valid && results_mode &&
            (s_q.fl == FL_IDLE || (s_q.fl == FL_CGAP && fl_adv))) begin
            pop        = 1'b1;
            s_d.code   = s_q.fifo[s_q.rp];
            s_d.digit  = 2'd0;
            s_d.blinks = flc_blinks(s_q.fifo[s_q.rp][15:12]);
            s_d.timer  = T_LONG_TK - 11'h001;
            s_d.fl     = FL_ON;
        end
        if (!results_mode) begin
            s_d.fl       = FL_IDLE;
            s_d.scan_idx = 2'd0;
            s_d.scan_hit = 1'b0;
        end

        // =====================================================
        // two-entry buffer; a stalled flasher holds the scanner off
        if (push) begin
            s_d.fifo[s_q.wp] = push_code;
            s_d.wp           = ~s_q.wp;
        end
        if (pop) begin
            s_d.rp = ~s_q.rp;
        end
        s_d.fcnt = s_q.fcnt + 2'(push) - 2'(pop);
        if (!results_mode) begin
            // stale codes must not survive a mode change
            s_d.fcnt = 2'd0;
            s_d.wp   = 1'b0;
            s_d.rp   = 1'b0;
        end

        // =====================================================
        // lamp select
        if (results_mode) begin
            s_d.lamp = (s_q.fl == FL_ON);
        end else if (o2_mode) begin
            s_d.lamp = closed_loop ? o2_lean : s_q.lamp;
        end else begin
            s_d.lamp = s_q.warn;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q    <= '0;
            s_q.fl <= FL_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign fault_lamp  = s_q.lamp;
    assign warn_lamp   = s_q.warn;
    assign diag_active = s_q.diag;

endmodule // flc_top

// >>> bench/flc_monitor.sv
// checker on the ports of the lamp flasher top, attached by bind
// assumes one clock, async active-low reset, blink figures in ms times TICK_CYCLES
`timescale 1ns/100ps
module flc_monitor #(
    parameter int unsigned TICK_CYCLES = flc_pkg::TICK_CYC
) (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire logic                ign_on,
    input wire logic                eng_running,
    input wire logic                diag_enter,
    input wire logic                erase_req,
    input wire logic                closed_loop,
    input wire logic                o2_lean,
    input wire flc_pkg::flc_snap_t  op_now,
    input wire flc_pkg::flc_fault_t fault_in,
    input wire flc_pkg::flc_pass_t  pass_in,
    input wire flc_pkg::flc_trip_t  trip_in,
    input wire logic                fault_lamp,
    input wire logic                warn_lamp,
    input wire logic                diag_active
);
    import flc_pkg::*;
    localparam int unsigned ON_S = T_SHORT_MS * TICK_CYCLES;
    localparam int unsigned ON_L = T_LONG_MS * TICK_CYCLES;
    localparam int unsigned OFF_MAX = T_CGAP_MS * TICK_CYCLES;
    logic        disp;
    logic        arm_q;
    logic        prev_q;
    logic [31:0] on_q;
    logic [31:0] off_q;
    assign disp = ign_on && diag_active && !eng_running;
    // =========================================
    // run lengths; erase disarms the length check until the lamp next rises
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arm_q <= 1'b0;
            prev_q <= 1'b0;
            on_q <= 32'h0;
            off_q <= 32'h0;
        end else begin
            arm_q <= disp && !erase_req && (arm_q || (fault_lamp && !prev_q));
            prev_q <= fault_lamp;
            on_q <= (disp && fault_lamp) ? on_q + 32'h1 : 32'h0;
            off_q <= (disp && !fault_lamp && !erase_req) ? off_q + 32'h1 : 32'h0;
        end
    end
    // =========================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_lean_follow: assert property ((diag_active && eng_running && ign_on && closed_loop)[*2]
        |=> fault_lamp == $past(o2_lean)) else $error("lamp does not follow mixture");
    a_open_hold: assert property ((diag_active && eng_running && ign_on)[*2] ##0 !closed_loop
        |=> $stable(fault_lamp)) else $error("lamp moved in open loop");
    a_ign_exit: assert property (!ign_on |=> !diag_active) else $error("mode kept");
    a_warn_cause: assert property ($rose(warn_lamp) |-> $past(fault_in.valid))
        else $error("warn lamp rose without fault");
    a_warn_drop: assert property ($fell(warn_lamp) |-> $past(trip_in.valid || erase_req))
        else $error("warn lamp fell without trip");
    a_normal_mirror: assert property (ign_on && !diag_active ##1 ign_on && !diag_active
        |-> fault_lamp == $past(warn_lamp)) else $error("lamp not mirroring warning");
    a_blink_len: assert property (disp && arm_q && $fell(fault_lamp)
        |-> on_q == ON_S || on_q == ON_L) else $error("blink on time wrong");
    a_gap_bound: assert property (disp && !fault_lamp |-> off_q < OFF_MAX)
        else $error("lamp dark too long");
    a_flash_starts: assert property ($rose(diag_active) && !eng_running && ign_on
        |-> ##[1:6] fault_lamp) else $error("flashing did not start");
    c_warn_off: cover property ($fell(warn_lamp));
    c_blink: cover property (disp && $rose(fault_lamp));
    c_lean: cover property (diag_active && eng_running && $rose(fault_lamp));
endmodule // flc_monitor

bind flc_top flc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (.clk(clk), .reset_n(reset_n),
    .ign_on(ign_on), .eng_running(eng_running), .diag_enter(diag_enter),
    .erase_req(erase_req), .closed_loop(closed_loop), .o2_lean(o2_lean), .op_now(op_now),
    .fault_in(fault_in), .pass_in(pass_in), .trip_in(trip_in), .fault_lamp(fault_lamp),
    .warn_lamp(warn_lamp), .diag_active(diag_active));

// >>> bench/flc_lamp_watch.sv
// technician watching the lamp: counts blinks, decodes four-digit codes
// assumes watch is high only while codes are flashed; flags any wrong run length
`timescale 1ns/100ps
module flc_lamp_watch #(
    parameter int unsigned TICK_CYCLES = 1
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        lamp,
    input  wire logic        watch,
    output logic [15:0]      code_seen,
    output logic             code_stb,
    output logic             bad_timing
);
    import flc_pkg::*;
    localparam int unsigned LG = T_LONG_MS * TICK_CYCLES;
    localparam int unsigned SH = T_SHORT_MS * TICK_CYCLES;
    localparam int unsigned DG = T_DGAP_MS * TICK_CYCLES;
    localparam int unsigned CG = T_CGAP_MS * TICK_CYCLES;
    logic        last_q;
    logic [31:0] len_q;
    logic [3:0]  blinks_q;
    logic [1:0]  dig_q;
    logic [15:0] acc_q;
    function automatic logic [3:0] dval(input logic [3:0] b);
        return (b == 4'hA) ? 4'h0 : b;
    endfunction
    // a saturated length means the run began before watching, so it is not judged
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_q <= 1'b0;
            len_q <= '1;
            blinks_q <= 4'h0;
            dig_q <= 2'h0;
            acc_q <= 16'h0;
            code_seen <= 16'h0;
            code_stb <= 1'b0;
            bad_timing <= 1'b0;
        end else begin
            code_stb <= 1'b0;
            last_q <= lamp;
            if (!watch) begin
                len_q <= '1;
                blinks_q <= 4'h0;
                dig_q <= 2'h0;
                acc_q <= 16'h0;
            end else if (lamp && !last_q) begin
                len_q <= 32'h1;
                if (len_q >= CG && blinks_q != 4'h0) begin
                    if (len_q != CG) bad_timing <= 1'b1;
                    code_seen <= {acc_q[11:0], dval(blinks_q)};
                    code_stb <= 1'b1;
                    acc_q <= 16'h0;
                    dig_q <= 2'h0;
                    blinks_q <= 4'h0;
                end else if (len_q >= DG && blinks_q != 4'h0) begin
                    if (len_q != DG) bad_timing <= 1'b1;
                    acc_q <= {acc_q[11:0], dval(blinks_q)};
                    dig_q <= dig_q + 2'h1;
                    blinks_q <= 4'h0;
                end else if (blinks_q != 4'h0 && len_q != ((dig_q == 2'h0) ? LG : SH)) begin
                    bad_timing <= 1'b1;
                end
            end else if (!lamp && last_q) begin
                len_q <= 32'h1;
                if (len_q != '1) begin
                    blinks_q <= blinks_q + 4'h1;
                    if (len_q != ((dig_q == 2'h0) ? LG : SH)) bad_timing <= 1'b1;
                end
            end else if (len_q != '1) begin
                len_q <= len_q + 32'h1;
            end
        end
    end
endmodule // flc_lamp_watch

// >>> bench/flc_top_test.sv
// self-checking bench for the lamp flasher and trip counters
// assumes a one-cycle tick so each ms of blink timing is one clock
`timescale 1ns/100ps
module flc_top_test;
    import flc_pkg::*;
    localparam int unsigned TK = 1;
    logic clk, reset_n, ign_on, eng_running, diag_enter, erase_req, closed_loop, o2_lean;
    logic fault_lamp, warn_lamp, diag_active, watch_en, code_stb, bad_timing;
    logic [15:0] code_seen;
    flc_snap_t op_now;
    flc_fault_t fault_in;
    flc_pass_t pass_in;
    flc_trip_t trip_in;
    int err_count, checked, cyc;
    flc_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .reset_n(reset_n), .ign_on(ign_on),
        .eng_running(eng_running), .diag_enter(diag_enter), .erase_req(erase_req),
        .closed_loop(closed_loop), .o2_lean(o2_lean), .op_now(op_now), .fault_in(fault_in),
        .pass_in(pass_in), .trip_in(trip_in), .fault_lamp(fault_lamp), .warn_lamp(warn_lamp),
        .diag_active(diag_active));
    flc_lamp_watch #(.TICK_CYCLES(TK)) eye (.clk(clk), .reset_n(reset_n), .lamp(fault_lamp),
        .watch(diag_active && !eng_running && watch_en), .code_seen(code_seen),
        .code_stb(code_stb), .bad_timing(bad_timing));
    always #12.5 clk = ~clk;
    // =========================================
    // helpers; every driver assigns on a rising edge, every look is at a falling edge
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic fault(input logic [1:0] s, input logic [15:0] c, input logic m = 1'b0);
        @(posedge clk) fault_in <= '{valid: 1'b1, slot: s, code: c, misfire: m};
        @(posedge clk) fault_in.valid <= 1'b0;
    endtask
    task automatic trip(input logic qa, input logic qb);
        @(posedge clk) trip_in <= '{valid: 1'b1, qual_a: qa, qual_b: qb};
        @(posedge clk) trip_in <= '0;
    endtask
    task automatic enter();
        @(posedge clk) ign_on <= 1'b1;
        @(posedge clk) diag_enter <= 1'b1;
        @(posedge clk) diag_enter <= 1'b0;
    endtask
    task automatic erase();
        @(posedge clk) erase_req <= 1'b1;
        @(posedge clk) erase_req <= 1'b0;
    endtask
    task automatic show_code(input logic [15:0] exp);
        int n;
        n = 0;
        enter();
        while (code_stb !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        check("shown code", code_seen, exp);
        @(posedge clk) ign_on <= 1'b0;
        look(2);
        check("mode after ignition off", {15'h0, diag_active}, 16'h0);
    endtask
    // =========================================
    // scenarios
    task automatic t_pending();
        @(posedge clk) ign_on <= 1'b1;
        fault(2'h0, 16'h2131);
        look(3);
        check("warn after first detection", {15'h0, warn_lamp}, 16'h0);
        show_code(16'h2131);
    endtask
    task automatic t_confirm();
        @(posedge clk) ign_on <= 1'b1;
        trip(1'b0, 1'b0);
        fault(2'h0, 16'h2131);
        look(2);
        check("warn on second trip", {15'h0, warn_lamp}, 16'h1);
        look(1);
        check("lamp on second trip", {15'h0, fault_lamp}, 16'h1);
    endtask
    task automatic t_monitor();
        @(posedge clk) eng_running <= 1'b1;
        closed_loop <= 1'b1;
        enter();
        @(posedge clk) o2_lean <= 1'b1;
        look(3);
        check("lean lamp", {15'h0, fault_lamp}, 16'h1);
        @(posedge clk) o2_lean <= 1'b0;
        look(3);
        check("rich lamp", {15'h0, fault_lamp}, 16'h0);
        @(posedge clk) closed_loop <= 1'b0;
        o2_lean <= 1'b1;
        look(4);
        check("open loop hold", {15'h0, fault_lamp}, 16'h0);
        @(posedge clk) ign_on <= 1'b0;
        eng_running <= 1'b0;
    endtask
    task automatic t_lamp_off();
        @(posedge clk) ign_on <= 1'b1;
        repeat (2) trip(1'b0, 1'b1);
        fault(2'h0, 16'h2131);
        repeat (3) trip(1'b0, 1'b1);
        look(2);
        check("warn after two clean", {15'h0, warn_lamp}, 16'h1);
        trip(1'b0, 1'b1);
        look(2);
        check("warn after three clean", {15'h0, warn_lamp}, 16'h0);
    endtask
    task automatic t_hide();
        @(posedge clk) ign_on <= 1'b1;
        repeat (39) trip(1'b1, 1'b0);
        show_code(16'h2131);
        @(posedge clk) ign_on <= 1'b1;
        trip(1'b1, 1'b0);
        show_code(CODE_NONE);
    endtask
    task automatic t_erase();
        @(posedge clk) ign_on <= 1'b1;
        watch_en <= 1'b0;
        fault(2'h1, 16'h1400);
        trip(1'b0, 1'b0);
        fault(2'h1, 16'h1400);
        erase();
        look(2);
        check("erase refused outside mode", {15'h0, warn_lamp}, 16'h1);
        enter();
        erase();
        look(2);
        check("warn after erase", {15'h0, warn_lamp}, 16'h0);
        @(posedge clk) ign_on <= 1'b0;
    endtask
    task automatic t_misfire();
        watch_en <= 1'b1;
        fault(2'h1, 16'h1111);
        fault(2'h0, 16'h1222, 1'b1);
        @(posedge clk) pass_in <= '{valid: 1'b1, slot: 2'h0};
        @(posedge clk) pass_in <= '0;
        show_code(16'h1111);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        {clk, reset_n, ign_on, eng_running, diag_enter, erase_req, closed_loop, o2_lean} = '0;
        {err_count, checked, cyc} = '0;
        watch_en = 1'b1;
        op_now = '{rpm: 14'h0352, load: 8'h1E, temp: 8'sh50};
        fault_in = '0;
        pass_in = '0;
        trip_in = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        look(1);
        check("lamps after reset", {13'h0, fault_lamp, warn_lamp, diag_active}, 16'h0);
        t_pending();
        t_confirm();
        t_monitor();
        t_lamp_off();
        t_hide();
        check("blink timing", {15'h0, bad_timing}, 16'h0);
        t_erase();
        t_misfire();
        wrap_up();
    end
endmodule // flc_top_test
